// *** run_ctrl.sv ***
// Run control for a target core under debug
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module run_ctrl
  import run_ctrl_pkg::*;
(
  input  wire logic                             clock,
  input  wire logic                             nrst,
  input  wire logic [run_ctrl_pkg::ADDR_W-1:0]  addr,
  input  wire logic [run_ctrl_pkg::DATA_W-1:0]  wdata,
  input  wire logic                             wr,
  input  wire logic                             rd,
  output logic      [run_ctrl_pkg::DATA_W-1:0]  rdata,
  output logic                                  irq,
  input  wire logic                             debug_serial_line,
  input  wire logic                             target_irq_req,
  input  wire logic                             target_reset_req,
  input  wire logic                             watchdog_reset,
  input  wire logic                             core_retire,
  input  wire logic                             core_in_call,
  output logic                                  core_run,
  output logic                                  core_irq,
  output logic                                  core_reset,
  output logic                                  periph_halt,
  output logic                                  debug_mode,
  output logic                                  pc_break_en,
  output logic                                  trace_en,
  output logic                                  load_regs,
  output logic      [23:0]                      gpr_init,
  output logic      [23:0]                      sp_init,
  output logic      [23:0]                      pc_init,
  output logic      [7:0]                       psr_init
);
  import run_ctrl_pkg::*;

  // ************************************************
  // Declarations
  // ************************************************
  run_state_t             state;
  run_state_t             next_state;
  logic [1:0]             line_sync;
  logic [1:0]             irq_sync;
  logic [1:0]             rst_sync;
  logic                   rst_seen;
  logic                   step_over;
  logic                   irq_pending;
  logic                   resume;
  logic                   held;
  logic                   release_now;
  logic [2:0]             config_bits;
  logic [EV_W-1:0]        events;
  logic [EV_W-1:0]        mask;
  logic [EV_W-1:0]        ev_set;
  logic [EV_W-1:0]        ev_clr;
  logic [CNT_W-1:0]       count;
  logic [CNT_W-1:0]       limit;
  logic [23:0]            boot_vector_base;
  logic                   wr_cmd;
  logic                   line_break;
  logic                   time_break;
  logic                   step_end;
  logic                   reset_accept;
  logic                   reset_rise;
  logic                   elapsed_on;
  logic                   meas_valid;
  logic                   connected;

  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [DATA_W-1:0] word_of(input logic [CNT_W-1:0] v, input logic hi);
    logic [63:0] wide;
    wide = 64'(v);
    word_of = hi ? wide[63:32] : wide[31:0];
  endfunction

  function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] v,
                                             input logic [DATA_W-1:0] w,
                                             input logic hi);
    logic [63:0] wide;
    wide = 64'(v);
    if (hi) begin
      wide[63:32] = w;
    end else begin
      wide[31:0] = w;
    end
    merge = wide[CNT_W-1:0];
  endfunction

  // ************************************************
  // Input synchronisers
  // ************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      line_sync <= 2'h3;
      irq_sync  <= 2'h0;
      rst_sync  <= 2'h0;
    end else begin
      line_sync <= {line_sync[0], debug_serial_line};
      irq_sync  <= {irq_sync[0], target_irq_req};
      rst_sync  <= {rst_sync[0], target_reset_req};
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_seen <= 1'b0;
    end else begin
      rst_seen <= rst_sync[1];
    end
  end

  assign reset_rise = rst_sync[1] && !rst_seen;

  // ************************************************
  // Command decode and break sources
  // ************************************************
  assign wr_cmd     = wr && (addr == OFS_COMMAND);
  assign line_break = !line_sync[1] && (state != ST_HALT);
  assign elapsed_on = config_bits[CFG_ELAPSED_BRK];
  assign time_break = elapsed_on && (state != ST_HALT) && (count >= limit);
  assign step_end   = (state == ST_STEP) && core_retire && !(step_over && core_in_call);
  assign resume     = (state == ST_HALT) && wr_cmd &&
                      (wdata[CMD_RUN] || wdata[CMD_STEP_INTO] || wdata[CMD_STEP_OVER]);
  assign reset_accept = (state == ST_RUN) && (reset_rise || watchdog_reset);

  // ************************************************
  // Run state machine
  // ************************************************
  always_comb begin
    next_state = state;
    case (state)
      ST_HALT: begin
        if (wr_cmd && wdata[CMD_RUN]) begin
          next_state = ST_RUN;
        end else if (wr_cmd && (wdata[CMD_STEP_INTO] || wdata[CMD_STEP_OVER])) begin
          next_state = ST_STEP;
        end
      end
      ST_RUN: begin
        if (line_break || time_break || (wr_cmd && wdata[CMD_HALT])) begin
          next_state = ST_HALT;
        end
      end
      ST_STEP: begin
        if (step_end || line_break || time_break || (wr_cmd && wdata[CMD_HALT])) begin
          next_state = ST_HALT;
        end
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_HALT;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      step_over <= 1'b0;
    end else if (resume) begin
      step_over <= wdata[CMD_STEP_OVER] && !wdata[CMD_RUN];
    end
  end

  // ************************************************
  // Core and peripheral controls
  // ************************************************
  // Peripherals also stopped while suspended, so reads do not advance them
  assign periph_halt = (state == ST_HALT);
  assign debug_mode  = (state == ST_HALT);
  assign core_run    = (state != ST_HALT);

  // Reset passed to core only while running; suspended resets are refused
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_reset <= 1'b0;
    end else begin
      core_reset <= (state == ST_RUN) && rst_sync[1];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pc_break_en <= 1'b1;
    end else if (state == ST_HALT) begin
      pc_break_en <= 1'b1;
    end else if (reset_accept) begin
      pc_break_en <= 1'b0;
    end
  end

  assign trace_en = config_bits[CFG_TRACE_REQ] && !config_bits[CFG_ALT_FAMILY];

  // ************************************************
  // Interrupt holding
  // ************************************************
  assign held = (state == ST_HALT) ||
                ((state == ST_STEP) && !(step_over && core_in_call));
  assign release_now = (irq_pending && (state != ST_HALT) && !held) ||
                       (irq_pending && resume);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_pending <= 1'b0;
    end else if (irq_sync[1] && held && !resume) begin
      // Resume delivers the request itself, no second copy
      irq_pending <= 1'b1;
    end else if (release_now) begin
      irq_pending <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      core_irq <= 1'b0;
    end else begin
      core_irq <= release_now || (irq_sync[1] && !held && state != ST_HALT);
    end
  end

  // ************************************************
  // Execution counter
  // ************************************************
  // Width covers the full hour range; only cycles out of halt are counted, with no debug entry and exit overhead added
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (resume) begin
      count <= '0;
    end else if (state != ST_HALT && count != '1) begin
      count <= count + CNT_W'(1);
    end
  end

  assign meas_valid = !elapsed_on &&
                      (count > CNT_W'(MIN_MEAS_CYC));

  // ************************************************
  // Events and interrupt
  // ************************************************
  always_comb begin
    ev_set = '0;
    ev_set[EV_LINE_BREAK] = line_break;
    ev_set[EV_STEP_DONE]  = step_end;
    ev_set[EV_TIME_BREAK] = time_break;
    ev_set[EV_RESET_RUN]  = reset_accept;
    ev_set[EV_RESET_HALT] = (state == ST_HALT) && reset_rise;
  end

  assign ev_clr = (wr && addr == OFS_EVENTS) ? wdata[EV_W-1:0] : '0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      events <= '0;
    end else begin
      events <= (events & ~ev_clr) | ev_set;
    end
  end

  assign irq = |(events & mask);

  // ************************************************
  // Writable registers
  // ************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      config_bits <= CONFIG_RESET;
      mask        <= '0;
    end else if (wr) begin
      if (addr == OFS_CONFIG) begin
        config_bits <= wdata[2:0];
      end
      if (addr == OFS_MASK) begin
        mask <= wdata[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      limit <= '1;
    end else if (wr && addr == OFS_LIMIT_LO) begin
      limit <= merge(limit, wdata, 1'b0);
    end else if (wr && addr == OFS_LIMIT_HI) begin
      limit <= merge(limit, wdata, 1'b1);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boot_vector_base <= BOOT_VECTOR_INIT;
    end else if (wr && addr == OFS_BOOT_VECTOR) begin
      boot_vector_base <= wdata[23:0];
    end
  end

  // ************************************************
  // Connect-time register values
  // ************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      connected <= 1'b0;
      load_regs <= 1'b0;
    end else begin
      connected <= 1'b1;
      load_regs <= !connected;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gpr_init <= GPR_INIT;
      sp_init  <= SP_INIT;
      psr_init <= PSR_INIT;
      pc_init  <= BOOT_VECTOR_INIT;
    end else begin
      gpr_init <= GPR_INIT;
      sp_init  <= SP_INIT;
      psr_init <= PSR_INIT;
      pc_init  <= boot_vector_base;
    end
  end

  // ************************************************
  // Read port
  // ************************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (rd) begin
      case (addr)
        OFS_CONFIG:      rdata <= {29'h0, config_bits};
        OFS_STATUS:      rdata <= {25'h0, meas_valid, trace_en, irq_pending,
                                   pc_break_en, step_over, state};
        OFS_EVENTS:      rdata <= {27'h0, events};
        OFS_MASK:        rdata <= {27'h0, mask};
        OFS_COUNT_LO:    rdata <= word_of(count, 1'b0);
        OFS_COUNT_HI:    rdata <= word_of(count, 1'b1);
        OFS_LIMIT_LO:    rdata <= word_of(limit, 1'b0);
        OFS_LIMIT_HI:    rdata <= word_of(limit, 1'b1);
        OFS_BOOT_VECTOR: rdata <= {8'h0, boot_vector_base};
        default:         rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

endmodule

// *** run_ctrl_pkg.sv ***
// Shared constants for the debug run-control block
package run_ctrl_pkg;

  // ************************************************
  // Register bus
  // ************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFS_COMMAND     = 8'h00;
  localparam logic [7:0] OFS_CONFIG      = 8'h04;
  localparam logic [7:0] OFS_STATUS      = 8'h08;
  localparam logic [7:0] OFS_EVENTS      = 8'h0C;
  localparam logic [7:0] OFS_MASK        = 8'h10;
  localparam logic [7:0] OFS_COUNT_LO    = 8'h14;
  localparam logic [7:0] OFS_COUNT_HI    = 8'h18;
  localparam logic [7:0] OFS_LIMIT_LO    = 8'h1C;
  localparam logic [7:0] OFS_LIMIT_HI    = 8'h20;
  localparam logic [7:0] OFS_BOOT_VECTOR = 8'h24;

  // Command register bits (write only, self clearing)
  localparam int CMD_RUN       = 0;
  localparam int CMD_STEP_INTO = 1;
  localparam int CMD_STEP_OVER = 2;
  localparam int CMD_HALT      = 3;

  // Configuration register bits
  localparam int CFG_ALT_FAMILY   = 0;
  localparam int CFG_ELAPSED_BRK  = 1;
  localparam int CFG_TRACE_REQ    = 2;
  localparam logic [2:0] CONFIG_RESET = 3'h0;

  // Event bits
  localparam int EV_W          = 5;
  localparam int EV_LINE_BREAK = 0;
  localparam int EV_STEP_DONE  = 1;
  localparam int EV_TIME_BREAK = 2;
  localparam int EV_RESET_RUN  = 3;
  localparam int EV_RESET_HALT = 4;

  // ************************************************
  // Execution counter
  // ************************************************
  localparam longint CLK_HZ        = 40000000;
  localparam longint MAX_HOURS     = 6515;
  localparam longint MAX_CYC       = MAX_HOURS * 3600 * CLK_HZ;
  localparam int     CNT_W         = $clog2(MAX_CYC + 1);
  localparam longint MIN_MEAS_NS   = 3000;
  localparam longint MIN_MEAS_CYC  = (MIN_MEAS_NS * CLK_HZ + 999999999) / 1000000000;
  localparam int     ENTRY_EXIT_CYC = 40;

  // ************************************************
  // Core register values on connect
  // ************************************************
  localparam logic [23:0] GPR_INIT         = 24'h000000;
  localparam logic [23:0] SP_INIT          = 24'hFFFFFC;
  localparam logic [7:0]  PSR_INIT         = 8'h00;
  localparam logic [23:0] BOOT_VECTOR_INIT = 24'h008000;

  typedef enum logic [1:0] {
    ST_HALT,
    ST_RUN,
    ST_STEP
  } run_state_t;

endpackage

// *** run_ctrl_chk.sv ***
// Assertion checker for the debug run-control block
`timescale 1ns/1ps
module run_ctrl_chk
  import run_ctrl_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        debug_serial_line,
  input wire logic        target_irq_req,
  input wire logic        target_reset_req,
  input wire logic        watchdog_reset,
  input wire logic        core_run,
  input wire logic        core_irq,
  input wire logic        core_reset,
  input wire logic        periph_halt,
  input wire logic        debug_mode,
  input wire logic        pc_break_en,
  input wire logic        trace_en,
  input wire logic        load_regs,
  input wire logic [23:0] gpr_init,
  input wire logic [23:0] sp_init,
  input wire logic [23:0] pc_init,
  input wire logic [7:0]  psr_init
);
  // ************
  // Held request tracking
  // ************
  logic req_d1;
  logic req_d2;
  logic held;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      req_d1 <= 1'b0;
      req_d2 <= 1'b0;
      held   <= 1'b0;
    end else begin
      req_d1 <= target_irq_req;
      req_d2 <= req_d1;
      held   <= !core_run && (held || (req_d2 && !wr));
    end
  end

  // ************
  // Properties
  // ************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_halted;  (!core_run) [*2]; endsequence
  sequence s_line_low; (!debug_serial_line && !wr) [*4]; endsequence
  sequence s_rst_run; (target_reset_req && core_run) [*3]; endsequence

  property p_halt_out; periph_halt == !core_run && debug_mode == periph_halt; endproperty
  property p_held; s_halted |-> !core_irq; endproperty
  property p_release; $rose(core_run) && held |-> ##[0:1] core_irq; endproperty
  property p_line; s_line_low |-> ##[0:1] !core_run; endproperty
  property p_rst_pass; s_rst_run |-> ##[1:2] core_reset; endproperty
  property p_no_rst; s_halted |-> !core_reset; endproperty
  property p_wd; watchdog_reset && core_run |-> ##[1:2] !pc_break_en; endproperty
  property p_rearm; $fell(core_run) |-> ##[1:2] pc_break_en; endproperty
  property p_trace;
    wr && addr == OFS_CONFIG |=> trace_en == ($past(wdata[2]) && !$past(wdata[0]));
  endproperty
  property p_connect;
    load_regs |-> gpr_init == 24'h000000 && sp_init == 24'hFFFFFC && psr_init == 8'h00 ##1 !load_regs;
  endproperty
  property p_boot; wr && addr == OFS_BOOT_VECTOR |-> ##2 pc_init == $past(wdata[23:0], 2); endproperty

  a_halt_out: assert property (p_halt_out) else $error("halt outputs disagree with run state");
  a_held: assert property (p_held) else $error("interrupt delivered while halted");
  a_release: assert property (p_release) else $error("held interrupt not released on resume");
  a_line: assert property (p_line) else $error("low serial line did not break");
  a_rst_pass: assert property (p_rst_pass) else $error("target reset not passed while running");
  a_no_rst: assert property (p_no_rst) else $error("reset passed while halted");
  a_wd: assert property (p_wd) else $error("watchdog reset left breaks enabled");
  a_rearm: assert property (p_rearm) else $error("breaks not enabled on halt");
  a_trace: assert property (p_trace) else $error("trace enable wrong");
  a_connect: assert property (p_connect) else $error("connect values wrong");
  a_boot: assert property (p_boot) else $error("program counter start wrong");
endmodule

bind run_ctrl run_ctrl_chk run_ctrl_chk_i (.clock, .nrst, .addr, .wdata, .wr, .debug_serial_line, .target_irq_req,
  .target_reset_req, .watchdog_reset, .core_run, .core_irq, .core_reset, .periph_halt, .debug_mode, .pc_break_en,
  .trace_en, .load_regs, .gpr_init, .sp_init, .pc_init, .psr_init);

// *** target_core_model.sv ***
// Target core model: retires one instruction every GAP cycles while allowed
`timescale 1ns/1ps
module target_core_model #(
  parameter int GAP = 20
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic core_run,
  input  wire logic core_reset,
  input  wire logic call_req,
  output logic      core_retire,
  output logic      core_in_call
);
  int cnt;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt         <= 0;
      core_retire <= 1'b0;
    end else if (!core_run || core_reset) begin
      cnt         <= 0;
      core_retire <= 1'b0;
    end else begin
      core_retire <= (cnt == GAP - 1);
      cnt         <= (cnt == GAP - 1) ? 0 : cnt + 1;
    end
  end

  assign core_in_call = call_req & core_run;
endmodule

// *** debug_mode_run_control_tb_top.sv ***
// Self-checking bench for the debug run-control block
`timescale 1ns/1ps
module debug_mode_run_control_tb_top;
  import run_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] e;
  } row_t;
  logic        clock, nrst, wr, rd, dsl, ireq, rreq, wdog, call_req, retire, in_call;
  logic        irq, core_run, core_irq, core_reset, periph_halt, debug_mode, pc_break_en, trace_en, load_regs;
  logic [7:0]  addr, psr_init;
  logic [31:0] wdata, rdata, d;
  logic [23:0] gpr_init, sp_init, pc_init;
  int          errors, n_tests, n, i;
  row_t        rows [11] = '{'{OFS_COMMAND, 32'h0}, '{OFS_CONFIG, 32'h0}, '{OFS_STATUS, 32'h8},
    '{OFS_EVENTS, 32'h0}, '{OFS_MASK, 32'h0}, '{OFS_COUNT_LO, 32'h0}, '{OFS_COUNT_HI, 32'h0},
    '{OFS_LIMIT_LO, 32'hFFFFFFFF}, '{OFS_LIMIT_HI, 32'h0003FFFF}, '{OFS_BOOT_VECTOR, 32'h8000}, '{8'hFC, 32'h0}};

  run_ctrl run_ctrl_i (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .irq, .debug_serial_line(dsl),
    .target_irq_req(ireq), .target_reset_req(rreq), .watchdog_reset(wdog), .core_retire(retire),
    .core_in_call(in_call), .core_run, .core_irq, .core_reset, .periph_halt, .debug_mode, .pc_break_en,
    .trace_en, .load_regs, .gpr_init, .sp_init, .pc_init, .psr_init);
  target_core_model #(.GAP(20)) target_core_model_i (.clock, .nrst, .core_run, .core_reset, .call_req,
    .core_retire(retire), .core_in_call(in_call));

  // ************
  // Tasks
  // ************
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk32({31'h0, g}, {31'h0, e});
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_sig(input bit on_reset, input logic v);
    int k;
    for (k = 0; k < 400 && (on_reset ? core_reset : core_run) !== v; k++) cyc(1);
    if ((on_reset ? core_reset : core_run) !== v) begin
      errors++;
      results();
    end
  endtask
  task automatic watch(input int len);
    n = 0;
    repeat (len) begin
      n += int'(core_irq === 1'b1);
      cyc(1);
    end
  endtask

  // ************
  // Stimulus
  // ************
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    results();
  end
  initial begin
    {nrst, wr, rd, ireq, rreq, wdog, call_req, addr, wdata} = '0;
    dsl = 1'b1;
    errors = 0;
    n_tests = 0;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    cyc(1);
    chk1(debug_mode, 1'b1);
    chk1(load_regs, 1'b1);
    chk32({8'h00, sp_init}, 32'h00FFFFFC);
    chk32({gpr_init, psr_init}, 32'h0);
    chk32({8'h00, pc_init}, 32'h00008000);
    for (i = 0; i < 11; i++) begin
      rdr(rows[i].a);
      chk32(d, rows[i].e);
    end
    for (i = 0; i < 4; i++) begin
      wrt(OFS_CONFIG, {29'h0, i[1], 1'b0, i[0]});
      chk1(trace_en, i[1] & ~i[0]);
    end
    wrt(OFS_BOOT_VECTOR, 32'h00012340);
    cyc(1);
    chk32({8'h00, pc_init}, 32'h00012340);
    wrt(OFS_COMMAND, 32'h1);
    cyc(200);
    wrt(OFS_COMMAND, 32'h8);
    rdr(OFS_COUNT_LO);
    chk1(d >= 32'hC8 && d <= 32'hCC, 1'b1);
    rdr(OFS_STATUS);
    chk1(d[6], 1'b1);
    wrt(OFS_COMMAND, 32'h1);
    cyc(40);
    wrt(OFS_COMMAND, 32'h8);
    rdr(OFS_STATUS);
    chk1(d[6], 1'b0);
    wrt(OFS_LIMIT_HI, 32'h0);
    wrt(OFS_LIMIT_LO, 32'hC8);
    wrt(OFS_CONFIG, 32'h2);
    wrt(OFS_COMMAND, 32'h1);
    wait_sig(1'b0, 1'b0);
    rdr(OFS_COUNT_LO);
    chk1(d >= 32'hC8 && d <= 32'hCC, 1'b1);
    rdr(OFS_EVENTS);
    chk1(d[2], 1'b1);
    rdr(OFS_STATUS);
    chk1(d[6], 1'b0);
    wrt(OFS_EVENTS, 32'h1F);
    wrt(OFS_CONFIG, 32'h0);
    wrt(OFS_MASK, 32'h1);
    wrt(OFS_COMMAND, 32'h1);
    chk1(periph_halt, 1'b0);
    @(posedge clock) dsl <= 1'b0;
    cyc(4);
    @(posedge clock) dsl <= 1'b1;
    wait_sig(1'b0, 1'b0);
    chk1(periph_halt, 1'b1);
    chk1(irq, 1'b1);
    wrt(OFS_MASK, 32'h0);
    chk1(irq, 1'b0);
    wrt(OFS_EVENTS, 32'h1F);
    rdr(OFS_EVENTS);
    chk32(d, 32'h0);
    wrt(OFS_COMMAND, 32'h1);
    @(posedge clock) rreq <= 1'b1;
    wait_sig(1'b1, 1'b1);
    cyc(1);
    chk1(pc_break_en, 1'b0);
    @(posedge clock) rreq <= 1'b0;
    cyc(4);
    wrt(OFS_COMMAND, 32'h8);
    cyc(1);
    chk1(pc_break_en, 1'b1);
    wrt(OFS_COMMAND, 32'h1);
    @(posedge clock) wdog <= 1'b1;
    @(posedge clock) wdog <= 1'b0;
    cyc(2);
    chk1(pc_break_en, 1'b0);
    wrt(OFS_COMMAND, 32'h8);
    cyc(1);
    chk1(pc_break_en, 1'b1);
    wrt(OFS_COMMAND, 32'h2);
    @(posedge clock) ireq <= 1'b1;
    watch(30);
    chk1(n == 0, 1'b1);
    chk1(core_run, 1'b0);
    rdr(OFS_STATUS);
    chk1(d[4], 1'b1);
    rdr(OFS_EVENTS);
    chk32(d, 32'h0000000A);
    @(posedge clock) call_req <= 1'b1;
    wrt(OFS_COMMAND, 32'h4);
    watch(10);
    chk1(n > 5, 1'b1);
    @(posedge clock) call_req <= 1'b0;
    wait_sig(1'b0, 1'b0);
    cyc(5);
    @(posedge clock) ireq <= 1'b0;
    cyc(3);
    rdr(OFS_STATUS);
    chk1(d[4], 1'b1);
    wrt(OFS_COMMAND, 32'h1);
    watch(8);
    chk1(n == 1, 1'b1);
    rdr(OFS_STATUS);
    chk1(d[4], 1'b0);
    @(posedge clock) nrst <= 1'b0;
    cyc(1);
    chk1(periph_halt, 1'b1);
    @(posedge clock) nrst <= 1'b1;
    cyc(1);
    chk1(load_regs, 1'b1);
    chk32({8'h00, pc_init}, 32'h00008000);
    cyc(2);
    chk1(load_regs, 1'b0);
    results();
  end
endmodule
